// ===== design/lpwc_consts.svh
`ifndef LPWC_CONSTS_SVH
`define LPWC_CONSTS_SVH
`define LPWC_ADDR_W 8
`define LPWC_OFF_CTRL 8'h00
`define LPWC_OFF_STATUS 8'h04
`define LPWC_OFF_START0 8'h08
`define LPWC_OFF_BO_CTRL 8'h0C
`define LPWC_OFF_PDRUN 8'h10
`define LPWC_OFF_WDMODE 8'h14
`define LPWC_OFF_RTCOSC 8'h18
`define LPWC_OFF_CLKGATE 8'h1C
`define LPWC_OFF_TIMERS 8'h20
`define LPWC_OFF_SERMODE 8'h24
`define LPWC_OFF_IRQ_STAT 8'h28
`define LPWC_OFF_IRQ_EN 8'h2C
`define LPWC_OFF_IRQ_CLR 8'h30
`define LPWC_OFF_INTC_EN 8'h34
`define LPWC_SRC_PIN 0
`define LPWC_SRC_BOD 1
`define LPWC_SRC_WDT 2
`define LPWC_SRC_RTC1HZ 3
`define LPWC_SRC_RTC1K 4
`define LPWC_SRC_MTICK 5
`define LPWC_SRC_SER 6
`define LPWC_SRC_USB0 7
`define LPWC_SRC_USB1 8
`define LPWC_NSRC 9
`define LPWC_CTRL_DSLEEP 0
`define LPWC_CTRL_DPD 1
`define LPWC_BOD_IRQ_EN 0
`define LPWC_BOD_RST_EN 1
`define LPWC_BOD_KEEP 2
`define LPWC_PD_WDOSC 0
`define LPWC_WD_EN 0
`define LPWC_WD_RST 1
`define LPWC_WD_IRQ 2
`define LPWC_WD_FED 3
`define LPWC_RTC_1HZ 0
`define LPWC_RTC_1KHZ 1
`define LPWC_CG_RTC 0
`define LPWC_CG_MTICK 1
`define LPWC_TM_COUNT 0
`define LPWC_TM_WAKE 1
`define LPWC_TM_MTICK 2
`define LPWC_SER_USART_SL 0
`define LPWC_SER_USART_32K 1
`define LPWC_SER_SPI_SL 2
`define LPWC_SER_I2C_SL 3
`define LPWC_EV_WAKE 0
`define LPWC_EV_RST 1
`define LPWC_EV_DPD_WAKE 2
`define LPWC_NEV 3
`define LPWC_RESP_OK 2'h0
`define LPWC_RESP_SLVERR 2'h2
`endif

// ===== design/lpwc_pkg.sv
package lpwc_pkg;
    typedef enum logic [2:0] {
        LPWC_ACTIVE = 3'b001,
        LPWC_DSLEEP = 3'b010,
        LPWC_DPD = 3'b100
    } lpwc_mode_e;
endpackage

// ===== design/lpwc_top.sv
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "lpwc_consts.svh"
module lpwc_top
    import lpwc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_reset_pin_n,
    input wire logic i_pin_irq,
    input wire logic i_bod_irq,
    input wire logic i_bod_reset,
    input wire logic i_wdt_irq,
    input wire logic i_wdt_timeout,
    input wire logic i_one_hertz_alarm_flag,
    input wire logic i_rtc_wake_irq,
    input wire logic i_mtick_irq,
    input wire logic i_usart_irq,
    input wire logic i_spi_irq,
    input wire logic i_i2c_irq,
    input wire logic i_usb0_need_clk,
    input wire logic i_usb1_need_clk,
    input wire logic [`LPWC_ADDR_W-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [`LPWC_ADDR_W-1:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [2:0] o_mode,
    output logic o_wake_req,
    output logic o_chip_reset,
    output logic o_core_power_on,
    output logic o_rtc_power_on,
    output logic o_pins_tristate,
    output logic o_irq
);
    localparam int NS = `LPWC_NSRC;

    // Pin synchronisers, two stages each
    localparam int NI = 14;
    logic [NI-1:0] sync1;
    logic [NI-1:0] sync2;
    always_ff @(posedge i_clk) begin
        sync1 <= {i_reset_pin_n, i_pin_irq, i_bod_irq, i_bod_reset, i_wdt_irq,
            i_wdt_timeout, i_one_hertz_alarm_flag, i_rtc_wake_irq, i_mtick_irq,
            i_usart_irq, i_spi_irq, i_i2c_irq, i_usb0_need_clk, i_usb1_need_clk};
        sync2 <= sync1;
    end
    logic rst_pin_n, s_pin, s_bod, s_bod_rst, s_wdt, s_wdt_to, s_alarm, s_rtcwk;
    logic s_mtick, s_usart, s_spi, s_i2c, s_usb0, s_usb1;
    assign {rst_pin_n, s_pin, s_bod, s_bod_rst, s_wdt, s_wdt_to, s_alarm, s_rtcwk,
        s_mtick, s_usart, s_spi, s_i2c, s_usb0, s_usb1} = sync2;

    lpwc_mode_e mode;
    logic [1:0] ctrl;
    logic [NS-1:0] start0;
    logic [2:0] bo_ctrl;
    logic pdrun;
    logic [3:0] wdmode;
    logic [1:0] rtcosc;
    logic [1:0] clkgate;
    logic [2:0] timers;
    logic [3:0] sermode;
    logic [NS-1:0] intc_en;
    logic [`LPWC_NEV-1:0] irq_stat;
    logic [`LPWC_NEV-1:0] irq_en;
    logic wake_dsleep, wake_dpd, rst_dsleep, pin_reset;
    logic [NS-1:0] src_ev;
    logic [NS-1:0] src_ok;

    // power-domain loss: deep power-down wake or reset pin clears
    logic dom_clear;
    assign pin_reset = ~rst_pin_n;
    assign dom_clear = i_rst | pin_reset | (mode == LPWC_DPD && wake_dpd);

    logic ser_ev;
    assign ser_ev = (s_usart & (sermode[`LPWC_SER_USART_SL] | sermode[`LPWC_SER_USART_32K]))
        | (s_spi & sermode[`LPWC_SER_SPI_SL]) | (s_i2c & sermode[`LPWC_SER_I2C_SL]);

    always_comb begin
        src_ev = '0;
        src_ok = '1;
        src_ev[`LPWC_SRC_PIN] = s_pin;
        src_ok[`LPWC_SRC_PIN] = intc_en[`LPWC_SRC_PIN];
        src_ev[`LPWC_SRC_BOD] = s_bod;
        src_ok[`LPWC_SRC_BOD] = intc_en[`LPWC_SRC_BOD] & bo_ctrl[`LPWC_BOD_IRQ_EN]
            & bo_ctrl[`LPWC_BOD_KEEP];
        src_ev[`LPWC_SRC_WDT] = s_wdt;
        src_ok[`LPWC_SRC_WDT] = intc_en[`LPWC_SRC_WDT] & pdrun & wdmode[`LPWC_WD_EN]
            & wdmode[`LPWC_WD_FED] & wdmode[`LPWC_WD_IRQ];
        src_ev[`LPWC_SRC_RTC1HZ] = s_alarm;
        src_ok[`LPWC_SRC_RTC1HZ] = rtcosc[`LPWC_RTC_1HZ] & timers[`LPWC_TM_COUNT]
            & clkgate[`LPWC_CG_RTC];
        src_ev[`LPWC_SRC_RTC1K] = s_rtcwk;
        src_ok[`LPWC_SRC_RTC1K] = rtcosc[`LPWC_RTC_1HZ] & rtcosc[`LPWC_RTC_1KHZ]
            & timers[`LPWC_TM_WAKE];
        src_ev[`LPWC_SRC_MTICK] = s_mtick;
        src_ok[`LPWC_SRC_MTICK] = pdrun & clkgate[`LPWC_CG_MTICK] & timers[`LPWC_TM_MTICK];
        src_ev[`LPWC_SRC_SER] = ser_ev;
        src_ev[`LPWC_SRC_USB0] = s_usb0;
        src_ev[`LPWC_SRC_USB1] = s_usb1;
    end

    assign wake_dsleep = |(src_ev & src_ok & start0);
    assign rst_dsleep = (s_bod_rst & bo_ctrl[`LPWC_BOD_RST_EN])
        | (s_wdt_to & pdrun & wdmode[`LPWC_WD_EN] & wdmode[`LPWC_WD_RST]
        & wdmode[`LPWC_WD_FED]);
    // only alarm paths raise wake_dpd; the reset pin also ends deep power-down
    assign wake_dpd = rtcosc[`LPWC_RTC_1HZ] & timers[`LPWC_TM_COUNT]
        & (s_alarm | (s_rtcwk & rtcosc[`LPWC_RTC_1KHZ] & timers[`LPWC_TM_WAKE]));

    // Mode sequencer
    always_ff @(posedge i_clk) begin
        if (i_rst || pin_reset) begin
            mode <= LPWC_ACTIVE;
        end else begin
            case (mode)
                LPWC_ACTIVE: begin
                    if (ctrl[`LPWC_CTRL_DPD]) begin
                        mode <= LPWC_DPD;
                    end else if (ctrl[`LPWC_CTRL_DSLEEP]) begin
                        mode <= LPWC_DSLEEP;
                    end
                end
                LPWC_DSLEEP: begin
                    if (wake_dsleep || rst_dsleep) begin
                        mode <= LPWC_ACTIVE;
                    end
                end
                LPWC_DPD: begin
                    if (wake_dpd) begin
                        mode <= LPWC_ACTIVE;
                    end
                end
                default: mode <= LPWC_ACTIVE;
            endcase
        end
    end

    assign o_mode = mode;
    assign o_wake_req = (mode == LPWC_DSLEEP && wake_dsleep) || (mode == LPWC_DPD && wake_dpd)
        || pin_reset;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_chip_reset <= 1'b0;
        end else begin
            o_chip_reset <= pin_reset || (mode == LPWC_DSLEEP && rst_dsleep)
                || (mode == LPWC_DPD && wake_dpd);
        end
    end
    assign o_core_power_on = (mode != LPWC_DPD);
    assign o_rtc_power_on = 1'b1;
    assign o_pins_tristate = (mode == LPWC_DPD);

    // AXI4-Lite write path
    logic aw_hold, w_hold;
    logic [`LPWC_ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_do, wr_ok;
    assign o_awready = ~aw_hold & ~o_bvalid;
    assign o_wready = ~w_hold & ~o_bvalid;
    assign wr_do = aw_hold & w_hold & ~o_bvalid;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_hold <= 1'b1;
                aw_addr <= i_awaddr;
            end else if (wr_do) begin
                aw_hold <= 1'b0;
            end
            if (i_wvalid && o_wready) begin
                w_hold <= 1'b1;
                w_data <= i_wdata;
                w_strb <= i_wstrb;
            end else if (wr_do) begin
                w_hold <= 1'b0;
            end
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_bvalid <= 1'b0;
            o_bresp <= `LPWC_RESP_OK;
        end else if (wr_do) begin
            o_bvalid <= 1'b1;
            o_bresp <= wr_ok ? `LPWC_RESP_OK : `LPWC_RESP_SLVERR;
        end else if (i_bready) begin
            o_bvalid <= 1'b0;
        end
    end
    always_comb begin
        case (aw_addr)
            `LPWC_OFF_CTRL, `LPWC_OFF_START0, `LPWC_OFF_BO_CTRL, `LPWC_OFF_PDRUN,
            `LPWC_OFF_WDMODE, `LPWC_OFF_RTCOSC, `LPWC_OFF_CLKGATE, `LPWC_OFF_TIMERS,
            `LPWC_OFF_SERMODE, `LPWC_OFF_IRQ_EN, `LPWC_OFF_IRQ_CLR,
            `LPWC_OFF_INTC_EN: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    // Configuration registers, lost in deep power-down
    logic wb0, wb1;
    assign wb0 = wr_do & w_strb[0];
    assign wb1 = wr_do & w_strb[1];
    always_ff @(posedge i_clk) begin
        if (dom_clear) begin
            ctrl <= '0;
            start0 <= '0;
            bo_ctrl <= '0;
            pdrun <= 1'b0;
            wdmode <= '0;
            clkgate <= '0;
            timers <= '0;
            sermode <= '0;
            intc_en <= '0;
            irq_en <= '0;
        end else begin
            if (mode != LPWC_ACTIVE) begin
                ctrl <= '0;
            end else if (wb0 && aw_addr == `LPWC_OFF_CTRL) begin
                ctrl <= w_data[1:0];
            end
            if (wb0 && aw_addr == `LPWC_OFF_START0) begin
                start0[7:0] <= w_data[7:0];
            end
            if (wb1 && aw_addr == `LPWC_OFF_START0) begin
                start0[NS-1:8] <= w_data[NS-1:8];
            end
            if (wb0 && aw_addr == `LPWC_OFF_INTC_EN) begin
                intc_en[7:0] <= w_data[7:0];
            end
            if (wb1 && aw_addr == `LPWC_OFF_INTC_EN) begin
                intc_en[NS-1:8] <= w_data[NS-1:8];
            end
            if (wb0 && aw_addr == `LPWC_OFF_BO_CTRL) begin
                bo_ctrl <= w_data[2:0];
            end
            if (wb0 && aw_addr == `LPWC_OFF_PDRUN) begin
                pdrun <= w_data[`LPWC_PD_WDOSC];
            end
            if (wb0 && aw_addr == `LPWC_OFF_WDMODE) begin
                wdmode <= w_data[3:0];
            end
            if (wb0 && aw_addr == `LPWC_OFF_CLKGATE) begin
                clkgate <= w_data[1:0];
            end
            if (wb0 && aw_addr == `LPWC_OFF_TIMERS) begin
                timers <= w_data[2:0];
            end
            if (wb0 && aw_addr == `LPWC_OFF_SERMODE) begin
                sermode <= w_data[3:0];
            end
            if (wb0 && aw_addr == `LPWC_OFF_IRQ_EN) begin
                irq_en <= w_data[`LPWC_NEV-1:0];
            end
        end
    end
    // Always-on RTC oscillator control survives deep power-down
    always_ff @(posedge i_clk) begin
        if (i_rst || pin_reset) begin
            rtcosc <= '0;
        end else if (wb0 && aw_addr == `LPWC_OFF_RTCOSC) begin
            rtcosc <= w_data[1:0];
        end
    end

    // Sticky event status; set wins over clear
    logic [`LPWC_NEV-1:0] ev_set;
    logic [`LPWC_NEV-1:0] ev_clr;
    assign ev_set[`LPWC_EV_WAKE] = (mode == LPWC_DSLEEP) && wake_dsleep;
    assign ev_set[`LPWC_EV_RST] = (mode == LPWC_DSLEEP) && rst_dsleep;
    assign ev_set[`LPWC_EV_DPD_WAKE] = (mode == LPWC_DPD) && wake_dpd;
    assign ev_clr = (wb0 && aw_addr == `LPWC_OFF_IRQ_CLR) ? w_data[`LPWC_NEV-1:0] : '0;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= (irq_stat & ~ev_clr) | ev_set;
        end
    end
    assign o_irq = |(irq_stat & irq_en);

    // AXI4-Lite read path
    logic [31:0] rd_val;
    logic rd_ok;
    assign o_arready = ~o_rvalid;
    always_comb begin
        rd_val = '0;
        rd_ok = 1'b1;
        case (i_araddr)
            `LPWC_OFF_CTRL: rd_val[1:0] = ctrl;
            `LPWC_OFF_STATUS: rd_val[2:0] = mode;
            `LPWC_OFF_START0: rd_val[NS-1:0] = start0;
            `LPWC_OFF_BO_CTRL: rd_val[2:0] = bo_ctrl;
            `LPWC_OFF_PDRUN: rd_val[0] = pdrun;
            `LPWC_OFF_WDMODE: rd_val[3:0] = wdmode;
            `LPWC_OFF_RTCOSC: rd_val[1:0] = rtcosc;
            `LPWC_OFF_CLKGATE: rd_val[1:0] = clkgate;
            `LPWC_OFF_TIMERS: rd_val[2:0] = timers;
            `LPWC_OFF_SERMODE: rd_val[3:0] = sermode;
            `LPWC_OFF_IRQ_STAT: rd_val[`LPWC_NEV-1:0] = irq_stat;
            `LPWC_OFF_IRQ_EN: rd_val[`LPWC_NEV-1:0] = irq_en;
            `LPWC_OFF_IRQ_CLR: rd_val = '0;
            `LPWC_OFF_INTC_EN: rd_val[NS-1:0] = intc_en;
            default: rd_ok = 1'b0;
        endcase
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rvalid <= 1'b0;
            o_rdata <= '0;
            o_rresp <= `LPWC_RESP_OK;
        end else if (i_arvalid && o_arready) begin
            o_rvalid <= 1'b1;
            o_rdata <= rd_val;
            o_rresp <= rd_ok ? `LPWC_RESP_OK : `LPWC_RESP_SLVERR;
        end else if (i_rready) begin
            o_rvalid <= 1'b0;
        end
    end
endmodule // lpwc_top

// ===== bench/lpwc_wake_src.sv
`timescale 1ns/1ps
module lpwc_wake_src (
    input wire logic i_clk,
    input wire logic [13:0] i_cmd,
    output logic [12:0] o_ev,
    output logic o_reset_pin_n
);
    initial o_ev = '0;
    initial o_reset_pin_n = 1'b1;
    // Event levels change just after an edge and hold until commanded
    always @(posedge i_clk) begin
        o_ev <= i_cmd[12:0];
        o_reset_pin_n <= ~i_cmd[13];
    end
endmodule // lpwc_wake_src

// ===== bench/lpwc_top_chk.sv
`timescale 1ns/1ps
module lpwc_top_chk (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_reset_pin_n,
    input wire logic i_one_hertz_alarm_flag,
    input wire logic i_rtc_wake_irq,
    input wire logic i_arvalid,
    input wire logic i_bready,
    input wire logic i_rready,
    input wire logic o_arready,
    input wire logic o_awready,
    input wire logic o_bvalid,
    input wire logic o_rvalid,
    input wire logic [2:0] o_mode,
    input wire logic o_wake_req,
    input wire logic o_core_power_on,
    input wire logic o_pins_tristate
);
    logic quiet;
    assign quiet = o_mode[2] && i_reset_pin_n && !i_one_hertz_alarm_flag && !i_rtc_wake_irq;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    chk_core_off: assert property ((o_mode == 3'b100) != o_core_power_on)
        else $error("core power wrong for mode");
    chk_pins_hiz: assert property ((o_mode == 3'b100) == o_pins_tristate)
        else $error("pin tri-state wrong for mode");
    chk_mode_onehot: assert property ($onehot(o_mode))
        else $error("mode not one-hot");
    chk_pin_wake: assert property ((!i_reset_pin_n) [*3] |-> o_wake_req)
        else $error("reset pin gave no wake");
    chk_dpd_quiet: assert property (quiet [*3] |-> !o_wake_req)
        else $error("wake from deep power-down without cause");
    chk_ar_resp: assert property (i_arvalid && o_arready |=> o_rvalid)
        else $error("read answer late");
    chk_r_drop: assert property (o_rvalid && i_rready |=> !o_rvalid)
        else $error("read answer kept after accept");
    chk_b_drop: assert property (o_bvalid && i_bready |=> !o_bvalid)
        else $error("write answer kept after accept");
    chk_aw_refuse: assert property (o_bvalid |-> !o_awready)
        else $error("address taken while answer pending");
endmodule // lpwc_top_chk
bind lpwc_top lpwc_top_chk u_lpwc_top_chk (.i_clk, .i_rst, .i_reset_pin_n,
    .i_one_hertz_alarm_flag, .i_rtc_wake_irq, .i_arvalid, .i_bready, .i_rready, .o_arready,
    .o_awready, .o_bvalid, .o_rvalid, .o_mode, .o_wake_req, .o_core_power_on, .o_pins_tristate);

// ===== bench/lpwc_top_bench.sv
`timescale 1ns/1ps
`include "lpwc_consts.svh"
module lpwc_top_bench;
    import lpwc_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [13:0] cmd = '0;
    logic [12:0] ev;
    logic pin_n;
    logic [7:0] i_awaddr = '0;
    logic [7:0] i_araddr = '0;
    logic [31:0] i_wdata = '0;
    logic [3:0] i_wstrb = 4'hF;
    logic i_awvalid = 1'b0;
    logic i_wvalid = 1'b0;
    logic i_bready = 1'b0;
    logic i_arvalid = 1'b0;
    logic i_rready = 1'b0;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_wake_req, o_chip_reset, o_irq;
    logic o_core_power_on, o_rtc_power_on, o_pins_tristate, woke, hit;
    logic [1:0] o_bresp, o_rresp;
    logic [31:0] o_rdata;
    logic [2:0] o_mode;
    logic [7:0] offs [9] = '{`LPWC_OFF_START0, `LPWC_OFF_INTC_EN, `LPWC_OFF_BO_CTRL,
        `LPWC_OFF_PDRUN, `LPWC_OFF_WDMODE, `LPWC_OFF_RTCOSC, `LPWC_OFF_CLKGATE,
        `LPWC_OFF_TIMERS, `LPWC_OFF_SERMODE};
    logic [31:0] msk [9] = '{'h1FF, 'h1FF, 7, 1, 'hF, 3, 3, 7, 'hF};
    int err_count = 0;
    int n_tests = 0;
    always #12.5 i_clk = ~i_clk;
    lpwc_wake_src u_lpwc_wake_src (.i_clk, .i_cmd(cmd), .o_ev(ev), .o_reset_pin_n(pin_n));
    lpwc_top u_lpwc_top (.i_clk, .i_rst, .i_reset_pin_n(pin_n), .i_pin_irq(ev[0]),
        .i_bod_irq(ev[1]), .i_bod_reset(ev[2]), .i_wdt_irq(ev[3]), .i_wdt_timeout(ev[4]),
        .i_one_hertz_alarm_flag(ev[5]), .i_rtc_wake_irq(ev[6]), .i_mtick_irq(ev[7]),
        .i_usart_irq(ev[8]), .i_spi_irq(ev[9]), .i_i2c_irq(ev[10]), .i_usb0_need_clk(ev[11]),
        .i_usb1_need_clk(ev[12]), .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
        .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
        .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .o_mode, .o_wake_req,
        .o_chip_reset, .o_core_power_on, .o_rtc_power_on, .o_pins_tristate, .o_irq);
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic hang();
        err_count++;
        $display("mismatch wait expected answer seen none");
        tally_and_finish();
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        int n;
        @(posedge i_clk);
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge i_clk);
            if (i_awvalid && o_awready) i_awvalid <= 1'b0;
            if (i_wvalid && o_wready) i_wvalid <= 1'b0;
            if (o_bvalid) break;
        end
        i_bready <= 1'b0;
        if (n == 40) hang();
        chk("bresp", 32'(o_bresp), 32'(er));
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = 0);
        int n;
        @(posedge i_clk);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge i_clk);
            if (i_arvalid && o_arready) i_arvalid <= 1'b0;
            if (o_rvalid) break;
        end
        i_rready <= 1'b0;
        if (n == 40) hang();
        chk("rresp", 32'(o_rresp), 32'(er));
        if (er == 2'h0) chk("rdata", o_rdata, exp);
    endtask
    task automatic restart();
        cmd <= '0;
        i_rst <= 1'b1;
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
    endtask
    task automatic to_mode(input logic [2:0] m);
        for (int n = 0; n < 40 && o_mode !== m; n++) @(posedge i_clk);
        if (o_mode !== m) hang();
    endtask
    task automatic watch(input int n);
        woke = 1'b0;
        hit = 1'b0;
        repeat (n) begin
            @(posedge i_clk);
            if (o_mode === 3'b001) woke = 1'b1;
            if (o_chip_reset === 1'b1) hit = 1'b1;
        end
    endtask
    // Kind 0 stays asleep, 1 wakes, 2 resets
    task automatic ds_case(input logic [31:0] v [9], input logic [13:0] e, input int kind);
        restart();
        foreach (v[k]) wr(offs[k], v[k]);
        wr(`LPWC_OFF_IRQ_EN, 32'h1);
        wr(`LPWC_OFF_CTRL, 32'h1);
        to_mode(3'b010);
        cmd <= e;
        watch(30);
        if (kind != 2) chk("ds wake", 32'(woke), 32'(kind == 1));
        chk("ds reset", 32'(hit), 32'(kind == 2));
        rd_chk(`LPWC_OFF_IRQ_STAT, 32'(kind));
    endtask
    task automatic irq_is(input logic v);
        repeat (2) @(posedge i_clk);
        chk("irq", 32'(o_irq), 32'(v));
    endtask
    task automatic dpd_case(input logic [31:0] rtc, tm, input logic [13:0] e, input logic exp);
        restart();
        wr(`LPWC_OFF_START0, 32'h1FF);
        wr(`LPWC_OFF_RTCOSC, rtc);
        wr(`LPWC_OFF_TIMERS, tm);
        wr(`LPWC_OFF_CTRL, 32'h2);
        to_mode(3'b100);
        chk("core on", 32'(o_core_power_on), 0);
        chk("rtc on", 32'(o_rtc_power_on), 1);
        chk("hi-z", 32'(o_pins_tristate), 1);
        cmd <= e;
        watch(30);
        chk("dpd wake", 32'(woke), 32'(exp));
        chk("dpd reset", 32'(hit), 32'(exp));
        if (!exp) begin
            cmd <= 14'h2000;
            watch(10);
            chk("pin wake", 32'(woke & hit), 1);
            cmd <= '0;
            watch(6);
        end
        rd_chk(`LPWC_OFF_START0, 0);
        rd_chk(`LPWC_OFF_RTCOSC, exp ? rtc : 0);
        rd_chk(`LPWC_OFF_IRQ_STAT, exp ? 32'h4 : 32'h0);
    endtask
    initial begin
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        rd_chk(`LPWC_OFF_STATUS, 32'h1);
        rd_chk(`LPWC_OFF_IRQ_CLR, 32'h0);
        foreach (offs[k]) rd_chk(offs[k], 32'h0);
        foreach (offs[k]) wr(offs[k], 32'hFFFFFFFF);
        foreach (offs[k]) rd_chk(offs[k], msk[k]);
        // Byte lanes: lane 0 alone, then lane 1 alone
        i_wstrb <= 4'h1;
        wr(`LPWC_OFF_START0, 32'h0);
        i_wstrb <= 4'h2;
        wr(`LPWC_OFF_INTC_EN, 32'h0);
        i_wstrb <= 4'hF;
        rd_chk(`LPWC_OFF_START0, 32'h100);
        rd_chk(`LPWC_OFF_INTC_EN, 32'hFF);
        rd_chk(8'h38, 32'h0, 2'h2);
        wr(`LPWC_OFF_STATUS, 32'h1, 2'h2);
        wr(8'h3C, 32'h1, 2'h2);
        ds_case('{1, 1, 0, 0, 0, 0, 0, 0, 0}, 'h1, 1);
        irq_is(1'b1);
        rd_chk(`LPWC_OFF_IRQ_STAT, 32'h1);
        wr(`LPWC_OFF_IRQ_EN, 32'h0);
        irq_is(1'b0);
        wr(`LPWC_OFF_IRQ_EN, 32'h1);
        irq_is(1'b1);
        wr(`LPWC_OFF_IRQ_CLR, 32'h1);
        irq_is(1'b0);
        rd_chk(`LPWC_OFF_IRQ_STAT, 32'h0);
        ds_case('{1, 0, 0, 0, 0, 0, 0, 0, 0}, 'h1, 0);
        ds_case('{2, 2, 5, 0, 0, 0, 0, 0, 0}, 'h2, 1);
        ds_case('{2, 2, 1, 0, 0, 0, 0, 0, 0}, 'h2, 0);
        ds_case('{0, 0, 2, 0, 0, 0, 0, 0, 0}, 'h4, 2);
        ds_case('{4, 4, 0, 1, 'hD, 0, 0, 0, 0}, 'h8, 1);
        ds_case('{4, 4, 0, 1, 5, 0, 0, 0, 0}, 'h8, 0);
        ds_case('{0, 0, 0, 1, 'hB, 0, 0, 0, 0}, 'h10, 2);
        ds_case('{8, 8, 0, 0, 0, 1, 1, 1, 0}, 'h20, 1);
        ds_case('{8, 8, 0, 0, 0, 1, 1, 0, 0}, 'h20, 0);
        ds_case('{'h10, 'h10, 0, 0, 0, 3, 1, 3, 0}, 'h40, 1);
        ds_case('{'h10, 'h10, 0, 0, 0, 1, 1, 3, 0}, 'h40, 0);
        ds_case('{'h20, 'h20, 0, 1, 0, 0, 2, 4, 0}, 'h80, 1);
        ds_case('{'h20, 'h20, 0, 1, 0, 0, 0, 4, 0}, 'h80, 0);
        ds_case('{'h40, 'h40, 0, 0, 0, 0, 0, 0, 1}, 'h100, 1);
        ds_case('{'h40, 'h40, 0, 0, 0, 0, 0, 0, 4}, 'h200, 1);
        ds_case('{'h40, 'h40, 0, 0, 0, 0, 0, 0, 8}, 'h400, 1);
        ds_case('{'h40, 'h40, 0, 0, 0, 0, 0, 0, 2}, 'h100, 1);
        ds_case('{'h40, 'h40, 0, 0, 0, 0, 0, 0, 0}, 'h700, 0);
        ds_case('{0, 0, 0, 0, 0, 0, 0, 0, 'hF}, 'h700, 0);
        ds_case('{'h80, 'h80, 0, 0, 0, 0, 0, 0, 0}, 'h800, 1);
        ds_case('{'h100, 'h100, 0, 0, 0, 0, 0, 0, 0}, 'h1000, 1);
        dpd_case(1, 1, 'h1B8B, 0);
        dpd_case(1, 1, 'h20, 1);
        dpd_case(1, 0, 'h20, 0);
        dpd_case(3, 3, 'h40, 1);
        tally_and_finish();
    end
endmodule // lpwc_top_bench
